// File: include/fmpc_pkg.sv
// fmpc_pkg: constants, register map and carrier structs of the frame memory pointer control.
// assumes one pclk domain; every device pin reaches the core through fmpc_pin_s.
package fmpc_pkg;
  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  localparam int ADDR_W  = 10;
  localparam int DEPTH   = 1 << ADDR_W;
  localparam int DATA_W  = 12;
  localparam int JUMP_W  = 24;
  localparam int BYTE_W  = 8;
  localparam int HADDR_W = 2;
  localparam int NCH     = 2;
  // ---------------------------------------------------------------------------
  // apb register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_CFG    = 8'h00;
  localparam logic [7:0] OFF_JUMP_A = 8'h04;
  localparam logic [7:0] OFF_JUMP_B = 8'h08;
  localparam logic [7:0] OFF_WCFG   = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_PTR_A  = 8'h14;
  localparam logic [7:0] OFF_PTR_B  = 8'h18;
  // ---------------------------------------------------------------------------
  // configuration word
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] flag_ctl;      // [7:4] channel b, [3:0] channel a
    logic [5:0] rsv_a;
    logic       clr_level;     // 1: read_pointer_clear level active
    logic       set_level;     // 1: read_pointer_set level active
    logic [4:0] rsv_b;
    logic [2:0] flag_thresh;   // upper_threshold / lower_threshold code
    logic [1:0] rsv_c;
    logic       read_target_select;
    logic [1:0] width;         // 0x: 8 bit, 10: 10 bit, 11: 12 bit
    logic [2:0] operating_config;
  } fmpc_cfg_s;
  localparam fmpc_cfg_s CFG_RST = fmpc_cfg_s'(32'h0000_0017);
  localparam logic [1:0] WIDTH_10 = 2'h2;
  localparam int NARROW_8  = 4;
  localparam int NARROW_10 = 2;
  // flag threshold fractions in eightieths
  localparam int TH_DEN    = 80;
  localparam int TH_BASE_K = 1;
  localparam int TH_STEP_K = 10;
  // timing-reference bit positions inside a data word
  localparam int TRS_F_BIT = 8;
  localparam int TRS_V_BIT = 7;
  localparam int TRS_H_BIT = 6;
  localparam int FCTL_W    = 4;
  localparam int FCTL_SRC  = 3;
  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [NCH-1:0]     write_clock;
    logic               read_clock;
    logic [NCH-1:0]     write_advance;
    logic [NCH-1:0]     write_mask;
    logic [NCH-1:0]     read_advance;
    logic [NCH-1:0]     write_pointer_mark;
    logic               read_pointer_set;
    logic               read_pointer_clear;
    logic               write_clear_b;
    logic [NCH-1:0]     output_enable;
    logic               global_reset_n;
    logic               config_commit;
    logic               host_port_select;
    logic               host_chip_select;
    logic               host_write_strobe;
    logic               host_read_strobe;
    logic [HADDR_W-1:0] host_addr;
    logic [BYTE_W-1:0]  host_data_in;
    logic [NCH-1:0][DATA_W-1:0] data_in;
    logic [DATA_W-1:0]  row_addr_in;
  } fmpc_pin_s;
  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fmpc_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fmpc_apb_rsp_s;
  function automatic logic fmpc_is_dual(input logic [2:0] op);
    return op[2];
  endfunction
endpackage

// File: design/fmpc_top.sv
// fmpc_top: pointer control, flags, output enables and configuration of the frame memory.
// assumes all video and host pins are asynchronous to pclk and are sampled through two flops.
// Functional notes
// - mark a copies write pointer a
// - mark b acts in dual modes only
// - dual set loads jump or marked value
// - single set loads mark, jump b, address
// - clear zeroes read pointers at read clock
// - clear gated by each read advance
// - write advance low stores word, high holds
// - mask blocks core write, pointer still moves
// - read advance high holds word and pointer
// - commit low copies preload into working
// - global reset zeroes pointers; commit low restores default configuration
// - enable high tristates; narrow widths drop bits
// - single modes tristate channel b output
// - parallel host writes and reads configuration
// - part full on lead above upper level
// - part empty on lead at most lower level
// - coincide flags show equal pointers
// - flag control routes timing bits to flags
// - default levels one and seventy-nine eightieths
// - set and clear default to falling edge
module fmpc_top
  import fmpc_pkg::*;
(
  input  wire logic                          pclk,             // register clock
  input  wire logic                          presetn,          // async reset, low
  input  wire fmpc_pkg::fmpc_apb_req_s       apb_req,          // apb request
  output      fmpc_pkg::fmpc_apb_rsp_s       apb_rsp,          // apb answer
  input  wire fmpc_pkg::fmpc_pin_s           pins_async,       // device pins
  output      logic [fmpc_pkg::DATA_W-1:0]   data_out_a,       // channel a word
  output      logic [fmpc_pkg::DATA_W-1:0]   data_out_a_oe_n,  // per bit, low drives
  output      logic [fmpc_pkg::DATA_W-1:0]   data_out_b,       // channel b word
  output      logic [fmpc_pkg::DATA_W-1:0]   data_out_b_oe_n,  // per bit, low drives
  output      logic                          part_full_a,      // channel a part full
  output      logic                          part_full_b,      // channel b part full
  output      logic                          part_empty_a,     // channel a part empty
  output      logic                          part_empty_b,     // channel b part empty
  output      logic                          pointer_coincide_a, // a pointers equal
  output      logic                          pointer_coincide_b, // b pointers equal
  output      logic [fmpc_pkg::BYTE_W-1:0]   host_data_out,    // parallel read data
  output      logic                          host_data_oe_n    // low drives host data
);
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] wptr;
    logic [ADDR_W-1:0] rptr;
    logic [ADDR_W-1:0] mark;
    logic [DATA_W-1:0] dout;
    logic              full;
    logic              empty;
    logic              coincide;
    logic              wadv_q;
    logic              radv_q;
    logic              set_pend;
    logic              clr_pend;
  } fmpc_ch_s;
  typedef struct packed {
    fmpc_pin_s                  sync1;
    fmpc_pin_s                  sync2;
    fmpc_pin_s                  prev;
    fmpc_ch_s [NCH-1:0]         ch;
    fmpc_cfg_s                  cfg_pre;
    fmpc_cfg_s                  cfg_wrk;
    logic [NCH-1:0][JUMP_W-1:0] jump_pre;
    logic [NCH-1:0][JUMP_W-1:0] jump_wrk;
    logic [31:0]                prdata;
    logic [BYTE_W-1:0]          host_rdata;
    logic                       host_oe_n;
    logic                       host_wr_done;
  } fmpc_state_s;

  fmpc_state_s s_q;
  fmpc_state_s s_d;
  logic [DATA_W-1:0] mem_q [NCH][DEPTH];
  logic [NCH-1:0]              mem_we;
  logic [NCH-1:0][ADDR_W-1:0]  mem_waddr;
  logic [NCH-1:0][DATA_W-1:0]  mem_wdata;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] full_level(input logic [2:0] code);
    int k;
    k = (code == 3'h0) ? TH_BASE_K : int'(code) * TH_STEP_K;
    return ADDR_W'(DEPTH - (DEPTH * k) / TH_DEN);
  endfunction

  function automatic logic [ADDR_W-1:0] empty_level(input logic [2:0] code);
    int k;
    k = (code == 3'h0) ? TH_BASE_K : int'(code) * TH_STEP_K;
    return ADDR_W'((DEPTH * k) / TH_DEN);
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    return (a == OFF_CFG) || (a == OFF_JUMP_A) || (a == OFF_JUMP_B) || (a == OFF_WCFG) ||
           (a == OFF_STATUS) || (a == OFF_PTR_A) || (a == OFF_PTR_B);
  endfunction

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    fmpc_pin_s         p;
    fmpc_pin_s         q;
    logic              act;
    logic              wrise;
    logic              rrise;
    logic              set_trig;
    logic              clr_trig;
    logic [ADDR_W-1:0] set_val;
    logic [ADDR_W-1:0] lead;
    logic [FCTL_W-1:0] fctl;
    logic [DATA_W-1:0] trs_word;
    logic [31:0]       word;
    logic              hsel;
    p        = s_q.sync2;
    q        = s_q.prev;
    act      = 1'b0;
    wrise    = 1'b0;
    rrise    = 1'b0;
    set_trig = 1'b0;
    clr_trig = 1'b0;
    set_val  = '0;
    lead     = '0;
    fctl     = '0;
    trs_word = '0;
    word     = '0;
    hsel     = 1'b0;
    s_d       = s_q;
    mem_we    = '0;
    mem_waddr = '0;
    mem_wdata = '0;
    s_d.sync1 = pins_async;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;

    // apb writes and setup-phase read capture
    if (apb_req.psel && apb_req.penable && apb_req.pwrite) begin
      case (apb_req.paddr)
        OFF_CFG:    s_d.cfg_pre     = fmpc_cfg_s'(apb_req.pwdata);
        OFF_JUMP_A: s_d.jump_pre[0] = apb_req.pwdata[JUMP_W-1:0];
        OFF_JUMP_B: s_d.jump_pre[1] = apb_req.pwdata[JUMP_W-1:0];
        default:    s_d.jump_pre    = s_d.jump_pre;
      endcase
    end
    if (apb_req.psel && !apb_req.penable) begin
      case (apb_req.paddr)
        OFF_CFG:    s_d.prdata = 32'(s_q.cfg_pre);
        OFF_JUMP_A: s_d.prdata = 32'(s_q.jump_pre[0]);
        OFF_JUMP_B: s_d.prdata = 32'(s_q.jump_pre[1]);
        OFF_WCFG:   s_d.prdata = 32'(s_q.cfg_wrk);
        OFF_STATUS: s_d.prdata = 32'({s_q.ch[1].coincide, s_q.ch[1].empty, s_q.ch[1].full,
                                      s_q.ch[0].coincide, s_q.ch[0].empty, s_q.ch[0].full});
        OFF_PTR_A:  s_d.prdata = {6'h00, s_q.ch[0].rptr, 6'h00, s_q.ch[0].wptr};
        OFF_PTR_B:  s_d.prdata = {6'h00, s_q.ch[1].rptr, 6'h00, s_q.ch[1].wptr};
        default:    s_d.prdata = 32'h0000_0000;
      endcase
    end

    // parallel host port, one byte of the preload word per strobe
    hsel = p.host_port_select && !p.host_chip_select;
    if (hsel && !p.host_write_strobe && !s_q.host_wr_done) begin
      word = 32'(s_d.cfg_pre);
      word[int'(p.host_addr) * BYTE_W +: BYTE_W] = p.host_data_in;
      s_d.cfg_pre = fmpc_cfg_s'(word);
    end
    s_d.host_wr_done = hsel && !p.host_write_strobe;
    word = 32'(s_q.cfg_pre);
    s_d.host_rdata = word[int'(p.host_addr) * BYTE_W +: BYTE_W];
    s_d.host_oe_n  = !(hsel && !p.host_read_strobe);

    // working configuration follows preload while commit is low
    if (!p.config_commit) begin
      s_d.cfg_wrk  = s_d.cfg_pre;
      s_d.jump_wrk = s_d.jump_pre;
    end

    // channels
    rrise = p.read_clock && !q.read_clock;
    for (int c = 0; c < NCH; c++) begin
      act   = (c == 0) || fmpc_is_dual(s_q.cfg_wrk.operating_config);
      wrise = p.write_clock[c] && !q.write_clock[c];
      fctl  = s_q.cfg_wrk.flag_ctl[c * FCTL_W +: FCTL_W];
      lead  = s_q.ch[c].wptr - s_q.ch[c].rptr;
      trs_word = fctl[FCTL_SRC] ? s_q.ch[c].dout : p.data_in[c];

      // write side: advance enable acts from the edge after it was sampled
      if (act && wrise) begin
        s_d.ch[c].wadv_q = p.write_advance[c];
        if (!s_q.ch[c].wadv_q) begin
          mem_we[c]       = !p.write_mask[c];
          mem_waddr[c]    = s_q.ch[c].wptr;
          mem_wdata[c]    = p.data_in[c];
          s_d.ch[c].wptr  = s_q.ch[c].wptr + 1'b1;
        end
        if (fctl[FCTL_SRC-1:0] != '0) begin
          s_d.ch[c].full = trs_word[TRS_F_BIT];
        end else begin
          s_d.ch[c].full = lead > full_level(s_q.cfg_wrk.flag_thresh);
        end
      end

      // mark captures the write pointer without touching it
      if (act && q.write_pointer_mark[c] && !p.write_pointer_mark[c]) begin
        s_d.ch[c].mark = s_q.ch[c].wptr;
      end

      // pointer set/clear: edge mode arms a one-shot, set wins over consumption
      s_d.ch[c].set_pend = (s_q.ch[c].set_pend && !rrise) ||
                           (q.read_pointer_set && !p.read_pointer_set);
      s_d.ch[c].clr_pend = (s_q.ch[c].clr_pend && !rrise) ||
                           (q.read_pointer_clear && !p.read_pointer_clear);
      set_trig = s_q.cfg_wrk.set_level ? !p.read_pointer_set : s_q.ch[c].set_pend;
      clr_trig = s_q.cfg_wrk.clr_level ? !p.read_pointer_clear : s_q.ch[c].clr_pend;

      if (fmpc_is_dual(s_q.cfg_wrk.operating_config)) begin
        set_val = s_q.cfg_wrk.read_target_select ?
                  s_q.jump_wrk[c][ADDR_W-1:0] : s_q.ch[c].mark;
      end else if (!s_q.cfg_wrk.read_target_select) begin
        set_val = s_q.ch[c].mark;
      end else if (!p.write_clear_b) begin
        set_val = s_q.jump_wrk[1][ADDR_W-1:0];
      end else begin
        set_val = ADDR_W'({p.row_addr_in, p.data_in[1]});
      end

      // read side
      if (act && rrise) begin
        s_d.ch[c].radv_q = p.read_advance[c];
        if (!s_q.ch[c].radv_q) begin
          if (clr_trig) begin
            s_d.ch[c].rptr = '0;
          end else if (set_trig) begin
            s_d.ch[c].rptr = set_val;
          end else begin
            s_d.ch[c].dout = mem_q[c][s_q.ch[c].rptr];
            s_d.ch[c].rptr = s_q.ch[c].rptr + 1'b1;
          end
        end
        if (fctl[FCTL_SRC-1:0] != '0) begin
          s_d.ch[c].empty = trs_word[TRS_V_BIT];
        end else begin
          s_d.ch[c].empty = lead <= empty_level(s_q.cfg_wrk.flag_thresh);
        end
      end

      if (!act) begin
        s_d.ch[c].coincide = 1'b0;
        s_d.ch[c].full     = 1'b0;
        s_d.ch[c].empty    = 1'b0;
      end else if (fctl[FCTL_SRC-1:0] != '0) begin
        s_d.ch[c].coincide = trs_word[TRS_H_BIT];
      end else begin
        s_d.ch[c].coincide = s_q.ch[c].wptr == s_q.ch[c].rptr;
      end
    end

    // synchronous global reset of pointers, marks and sequencing
    if (!p.global_reset_n) begin
      for (int c = 0; c < NCH; c++) begin
        s_d.ch[c] = '0;
      end
      mem_we = '0;
      if (!p.config_commit) begin
        s_d.cfg_pre  = CFG_RST;
        s_d.cfg_wrk  = CFG_RST;
        s_d.jump_pre = '0;
        s_d.jump_wrk = '0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // registers and memory core
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q           <= '0;
      s_q.cfg_pre   <= CFG_RST;
      s_q.cfg_wrk   <= CFG_RST;
      s_q.host_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge pclk) begin
    for (int c = 0; c < NCH; c++) begin
      if (mem_we[c]) begin
        mem_q[c][mem_waddr[c]] <= mem_wdata[c];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  always_comb begin
    logic dual;
    dual = fmpc_is_dual(s_q.cfg_wrk.operating_config);
    for (int i = 0; i < DATA_W; i++) begin
      data_out_a_oe_n[i] = s_q.sync2.output_enable[0] ||
                           (!s_q.cfg_wrk.width[1] && i < NARROW_8) ||
                           (s_q.cfg_wrk.width == WIDTH_10 && i < NARROW_10);
      data_out_b_oe_n[i] = s_q.sync2.output_enable[1] || !dual ||
                           (!s_q.cfg_wrk.width[1] && i < NARROW_8) ||
                           (s_q.cfg_wrk.width == WIDTH_10 && i < NARROW_10);
    end
  end

  assign data_out_a         = s_q.ch[0].dout;
  assign data_out_b         = s_q.ch[1].dout;
  assign part_full_a        = s_q.ch[0].full;
  assign part_full_b        = s_q.ch[1].full;
  assign part_empty_a       = s_q.ch[0].empty;
  assign part_empty_b       = s_q.ch[1].empty;
  assign pointer_coincide_a = s_q.ch[0].coincide;
  assign pointer_coincide_b = s_q.ch[1].coincide;
  assign host_data_out      = s_q.host_rdata;
  assign host_data_oe_n     = s_q.host_oe_n;
  assign apb_rsp.prdata     = s_q.prdata;
  assign apb_rsp.pready     = apb_req.psel && apb_req.penable;
  assign apb_rsp.pslverr    = apb_req.psel && apb_req.penable && !reg_mapped(apb_req.paddr);
endmodule

// File: bench/fmpc_properties.sv
// fmpc_properties: port checks of fmpc_top, bound to every instance.
// assumes pclk is the only clock and presetn the only reset.
module fmpc_properties (
  input wire logic                          pclk,               // clock
  input wire logic                          presetn,            // reset, low
  input wire fmpc_pkg::fmpc_apb_req_s       apb_req,            // apb request
  input wire fmpc_pkg::fmpc_apb_rsp_s       apb_rsp,            // apb answer
  input wire fmpc_pkg::fmpc_pin_s           pins_async,         // device pins
  input wire logic [fmpc_pkg::DATA_W-1:0]   data_out_a,         // a word
  input wire logic [fmpc_pkg::DATA_W-1:0]   data_out_a_oe_n,    // a enables
  input wire logic                          part_full_a,        // a part full
  input wire logic                          part_empty_a,       // a part empty
  input wire logic                          pointer_coincide_a, // a pointers equal
  input wire logic                          host_data_oe_n      // host data enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------
  // register access
  // ------
  ready_match_a: assert property (apb_rsp.pready == (apb_req.psel && apb_req.penable))
    else $error("pready not in step with the access phase");
  error_in_access_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr outside an access phase");
  error_reads_zero_a: assert property (apb_rsp.pslverr && !apb_req.pwrite |->
    apb_rsp.prdata == 32'h0) else $error("refused read returned data");
  read_data_held_a: assert property (!apb_req.psel ##1 !apb_req.psel |->
    $stable(apb_rsp.prdata)) else $error("prdata moved while idle");
  host_quiet_a: assert property (pins_async.host_read_strobe [*4] |-> host_data_oe_n)
    else $error("host data driven without a read strobe");
  // ------
  // data path and flags
  // ------
  off_tristates_a: assert property (pins_async.output_enable[0] [*4] |->
    &data_out_a_oe_n) else $error("channel a driven while disabled");
  dout_quiet_a: assert property ((!pins_async.read_clock &&
    pins_async.global_reset_n) [*5] |-> $stable(data_out_a))
    else $error("channel a word changed without a read clock");
  full_on_wclk_a: assert property ((!pins_async.write_clock[0] &&
    pins_async.global_reset_n) [*5] |-> $stable(part_full_a))
    else $error("part full moved without a write clock");
  empty_on_rclk_a: assert property ((!pins_async.read_clock &&
    pins_async.global_reset_n) [*5] |-> $stable(part_empty_a))
    else $error("part empty moved without a read clock");
  coincide_still_a: assert property ((!pins_async.write_clock[0] &&
    !pins_async.read_clock && pins_async.global_reset_n) [*6] |->
    $stable(pointer_coincide_a)) else $error("coincide moved with pointers idle");
endmodule
bind fmpc_top fmpc_properties i_props (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .pins_async(pins_async), .data_out_a(data_out_a), .data_out_a_oe_n(data_out_a_oe_n),
  .part_full_a(part_full_a), .part_empty_a(part_empty_a),
  .pointer_coincide_a(pointer_coincide_a), .host_data_oe_n(host_data_oe_n)
);

// File: bench/fmpc_vid.sv
// fmpc_vid: video source and sink logic facing the device pins.
// assumes the bench clock; pins move by nonblocking assignment after pclk rises.
module fmpc_vid (
  input  wire logic           pclk, // bench clock
  output fmpc_pkg::fmpc_pin_s p     // device pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------
  // pin strobes
  // ------
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one write clock on the channels in ch; channel b carries the inverse word
  task automatic wr(input logic [1:0] ch, input logic [11:0] d);
    p.data_in <= {~d, d};
    hold(4);
    p.write_clock <= ch;
    hold(4);
    p.write_clock <= 2'h0;
  endtask
  // one read clock, w cycles high and w low
  task automatic rd(input int w);
    p.read_clock <= 1'b1;
    hold(w);
    p.read_clock <= 1'b0;
    hold(w);
  endtask
  // falling edges on {clear, set, mark b, mark a}
  task automatic fall(input logic [3:0] m);
    p.write_pointer_mark <= ~m[1:0];
    p.read_pointer_set <= ~m[2];
    p.read_pointer_clear <= ~m[3];
    hold(4);
    p.write_pointer_mark <= 2'h3;
    p.read_pointer_set <= 1'b1;
    p.read_pointer_clear <= 1'b1;
    hold(4);
  endtask
  initial begin
    p = '0;
    p.write_advance = 2'h0;
    p.write_pointer_mark = 2'h3;
    p.read_pointer_set = 1'b1;
    p.read_pointer_clear = 1'b1;
    p.global_reset_n = 1'b1;
    p.config_commit = 1'b1;
    p.host_port_select = 1'b0;
    p.host_chip_select = 1'b1;
    p.host_write_strobe = 1'b1;
    p.host_read_strobe = 1'b1;
  end
endmodule

// File: bench/testbench.sv
// testbench: register and video pin sequences with expected values for fmpc_top.
// assumes fmpc_vid drives the pins and the bound checker watches the ports.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                    pclk;
  logic                    presetn;
  fmpc_pkg::fmpc_apb_req_s req;
  fmpc_pkg::fmpc_apb_rsp_s rsp;
  fmpc_pkg::fmpc_pin_s     pins;
  logic [11:0]             dout_a;
  logic [11:0]             oen_a;
  logic [11:0]             oen_b;
  logic [11:0]             dout_b;
  logic                    pf_b;
  logic                    pe_b;
  logic                    pf_a;
  logic                    pe_a;
  logic                    co_a;
  logic                    co_b;
  logic [7:0]              hdo;
  logic                    hoe_n;
  logic [31:0]             rd;
  logic                    err;
  int                      n_mismatch;
  int                      check_count;
  fmpc_top i_dut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .pins_async(pins),
    .data_out_a(dout_a), .data_out_a_oe_n(oen_a), .data_out_b(dout_b), .data_out_b_oe_n(oen_b),
    .part_full_a(pf_a), .part_full_b(pf_b), .part_empty_a(pe_a), .part_empty_b(pe_b),
    .pointer_coincide_a(co_a), .pointer_coincide_b(co_b),
    .host_data_out(hdo), .host_data_oe_n(hoe_n)
  );
  fmpc_vid vid (.pclk(pclk), .p(pins));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ------
  // helpers
  // ------
  task automatic results;
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 64);
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask
  function automatic logic [31:0] ptr(input logic [9:0] r, input logic [9:0] w);
    return {6'h0, r, 6'h0, w};
  endfunction
  // ------
  // sequence
  // ------
  initial begin
    req = '0;
    presetn = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, fmpc_pkg::OFF_WCFG, 32'h0, rd);
    rc(fmpc_pkg::OFF_CFG, 32'h17);
    rc(fmpc_pkg::OFF_WCFG, 32'h17);
    rc(fmpc_pkg::OFF_STATUS, 32'h24);
    apb(1'b0, 8'h1c, 32'h0, rd);
    chk({rd[30:0], err}, 32'h1);
    vid.p.write_mask <= 2'h2;
    vid.wr(2'h3, 12'h101);
    vid.p.write_advance[0] <= 1'b1;
    vid.wr(2'h3, 12'h102);
    vid.p.write_advance[0] <= 1'b0;
    vid.wr(2'h3, 12'h103);
    vid.wr(2'h3, 12'h104);
    rc(fmpc_pkg::OFF_PTR_A, ptr(10'h0, 10'h3));
    rc(fmpc_pkg::OFF_PTR_B, ptr(10'h0, 10'h4));
    vid.fall(4'h3);
    rc(fmpc_pkg::OFF_PTR_A, ptr(10'h0, 10'h3));
    rc(fmpc_pkg::OFF_PTR_B, ptr(10'h0, 10'h4));
    vid.p.read_advance[0] <= 1'b1;
    vid.rd(4);
    chk(32'(dout_a), 32'h101);
    chk(32'(pe_a), 32'h1);
    vid.fall(4'h8);
    vid.rd(6);
    rc(fmpc_pkg::OFF_PTR_A, ptr(10'h1, 10'h3));
    rc(fmpc_pkg::OFF_PTR_B, ptr(10'h0, 10'h4));
    chk(32'(dout_a), 32'h101);
    vid.p.read_advance[0] <= 1'b0;
    vid.rd(4);
    vid.rd(4);
    chk(32'(dout_a), 32'h102);
    vid.fall(4'h4);
    vid.rd(4);
    rc(fmpc_pkg::OFF_PTR_A, ptr(10'h3, 10'h3));
    rc(fmpc_pkg::OFF_PTR_B, ptr(10'h4, 10'h4));
    chk(32'({co_b, co_a}), 32'h3);
    vid.fall(4'h8);
    vid.rd(4);
    rc(fmpc_pkg::OFF_PTR_A, ptr(10'h0, 10'h3));
    for (int i = 0; i < 1008; i++)
      vid.wr(2'h1, i[11:0]);
    chk(32'(pf_a), 32'h0);
    repeat (3) vid.wr(2'h1, 12'h0);
    chk(32'(pf_a), 32'h1);
    chk(32'(oen_a), 32'h3);
    vid.p.output_enable[0] <= 1'b1;
    vid.hold(4);
    chk(32'(oen_a), 32'hfff);
    chk(32'(oen_b), 32'h3);
    apb(1'b1, fmpc_pkg::OFF_CFG, 32'h13, rd);
    rc(fmpc_pkg::OFF_WCFG, 32'h17);
    vid.p.config_commit <= 1'b0;
    vid.hold(4);
    rc(fmpc_pkg::OFF_WCFG, 32'h13);
    chk(32'(oen_b), 32'hfff);
    vid.p.config_commit <= 1'b1;
    vid.p.global_reset_n <= 1'b0;
    vid.hold(4);
    vid.p.global_reset_n <= 1'b1;
    vid.hold(4);
    rc(fmpc_pkg::OFF_PTR_A, 32'h0);
    rc(fmpc_pkg::OFF_CFG, 32'h13);
    vid.p.host_port_select <= 1'b1;
    vid.p.host_chip_select <= 1'b0;
    vid.p.host_data_in <= 8'h14;
    vid.p.host_write_strobe <= 1'b0;
    vid.hold(4);
    vid.p.host_write_strobe <= 1'b1;
    vid.hold(4);
    vid.p.config_commit <= 1'b0;
    vid.p.host_read_strobe <= 1'b0;
    vid.hold(4);
    rc(fmpc_pkg::OFF_WCFG, 32'h14);
    chk(32'({hoe_n, hdo}), 32'h14);
    vid.p.write_mask <= 2'h0;
    vid.p.write_advance <= 2'h2;
    vid.p.read_advance <= 2'h2;
    vid.p.output_enable <= 2'h3;
    vid.wr(2'h2, 12'h0a5);
    vid.wr(2'h2, 12'h0a6);
    vid.rd(4);
    vid.rd(4);
    rc(fmpc_pkg::OFF_PTR_B, ptr(10'h1, 10'h1));
    chk(32'(dout_b), 32'hf5a);
    chk(32'({pf_b, pe_b}), 32'h1);
    chk(32'(oen_b), 32'hfff);
    vid.p.write_advance <= 2'h0;
    vid.p.read_advance <= 2'h0;
    vid.p.host_addr <= 2'h1;
    vid.p.host_data_in <= 8'h07;
    vid.p.host_write_strobe <= 1'b0;
    vid.hold(4);
    vid.p.host_write_strobe <= 1'b1;
    vid.hold(4);
    chk(32'({hoe_n, hdo}), 32'h7);
    apb(1'b1, fmpc_pkg::OFF_CFG, 32'h733, rd);
    vid.p.write_clear_b <= 1'b1;
    vid.p.row_addr_in <= 12'h001;
    vid.p.data_in <= {12'h155, 12'h000};
    vid.fall(4'h4);
    vid.rd(4);
    rc(fmpc_pkg::OFF_PTR_A, ptr(10'h155, 10'h0));
    apb(1'b1, fmpc_pkg::OFF_CFG, 32'h1_0733, rd);
    apb(1'b1, fmpc_pkg::OFF_JUMP_B, 32'h2a, rd);
    vid.p.write_clear_b <= 1'b0;
    vid.p.read_pointer_set <= 1'b0;
    vid.rd(4);
    vid.p.read_pointer_set <= 1'b1;
    rc(fmpc_pkg::OFF_PTR_A, ptr(10'h2a, 10'h0));
    results();
  end
endmodule
